// [verilog/fsc_pkg.sv]
// Package of constants shared by the flyback switching controller.
package fsc_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MAX_FREQ_KHZ = 125;
  localparam int unsigned MIN_PERIOD_CYC = (CLK_MHZ * 1000) / MAX_FREQ_KHZ;
  localparam int unsigned DEMAG_BLANK_NS = 2000;
  localparam int unsigned DEMAG_BLANK_CYC = (DEMAG_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_ON_NS = 25000;
  localparam int unsigned MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / 1000;
  localparam int unsigned LEB_NS = 300;
  localparam int unsigned LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // Overvoltage counter.
  // ****************************************************************
  localparam int unsigned OVP_TRIP = 8;
  localparam int unsigned OVP_UP = 1;
  localparam int unsigned OVP_DOWN = 2;

  // ****************************************************************
  // Controller states.
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_WAIT_SUPPLY = 6'h01,
    ST_SOFT_START = 6'h02,
    ST_ON = 6'h04,
    ST_SECONDARY = 6'h08,
    ST_WAIT_VALLEY = 6'h10,
    ST_HALT = 6'h20
  } fsc_state_t;

endpackage : fsc_pkg

// [verilog/fsc_sync.sv]
// Two-flop synchroniser for a bank of comparator inputs.
`timescale 1ns/1ps
`default_nettype none
module fsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Data.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : fsc_sync
`default_nettype wire

// [verilog/fsc_flyback_switching_controller.sv]
// Flyback switching controller: gate sequencing, modes and protections.
//
// Overview of operation
// - Light load: valley skipping, cap 125 kHz.
// - Frequency reduction: oscillator slows, peak limit quarter.
// - Frequency reduction signals burst; 50 mV hysteresis.
// - After oscillator and demag, wait for valley.
// - Current reaching threshold ends on-time.
// - Gate latched; one turn-on per cycle.
// - No new stroke before secondary stroke ends.
// - Slow demag lengthens off-time cycle by cycle.
// - Ignore demag for 2 us after turn-off.
// - Aux open stops switching; auto resume.
// - Disconnect loop pull-up above 2.5 V.
// - Loop pin above 4.5 V inhibits switching.
// - Loop pin shorted to ground inhibits switching.
// - Soft-start current on at supply start level.
// - Start when bus sense and 0.5 V reached.
// - Soft-start current off once switching starts.
// - On-time over 25 us: safe restart.
// - Overvoltage sampled only during secondary stroke.
// - Counter up per event, down twice as fast.
// - Counter reaching 8 trips off and latches.
// - Overvoltage latch holds until supply collapses.
// - Blank overcurrent after turn-on.
`timescale 1ns/1ps
`default_nettype none
module fsc_flyback_switching_controller #(
  parameter int unsigned MAX_ON_CYCLES = fsc_pkg::MAX_ON_CYC,
  parameter int unsigned PERIOD_WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Comparator inputs from the analog front ends.
  input wire logic supplyStartup,
  input wire logic supplyUvlo,
  input wire logic busOutputSenseStart,
  input wire logic currentSenseSoftDone,
  input wire logic currentSenseTrip,
  input wire logic currentSenseQuarterTrip,
  input wire logic auxDemagDone,
  input wire logic auxValley,
  input wire logic auxOpen,
  input wire logic auxOvpEvent,
  input wire logic loopControlAbove2v5,
  input wire logic loopControlAbove4v5,
  input wire logic loopControlShorted,
  input wire logic loopControlFreqRedEnter,
  input wire logic loopControlFreqRedExit,
  // Controlled oscillator period request in clock cycles.
  input wire logic [PERIOD_WIDTH-1:0] oscPeriodCycles,
  // Outputs.
  output logic gateDriveOutput,
  output logic softStartCurrentEn,
  output logic loopPullupEn,
  output logic burstModeReq,
  output logic peakLimitQuarter,
  output logic ovpLatched,
  output logic safeRestart
);

  // ****************************************************************
  // Input synchronisation.
  // ****************************************************************
  localparam int unsigned NIN = 15;
  logic [NIN-1:0] syncIn;
  logic supUp, supLow, busStart, ssDone, csTrip, csQuarter, demag, valley;
  logic auxOpn, ovpEv, lc25, lc45, lcShort, frEnter, frExit;

  fsc_sync #(.WIDTH(NIN)) uSync (
    .clk(clk),
    .srst(srst),
    .asyncIn({supplyStartup, supplyUvlo, busOutputSenseStart, currentSenseSoftDone,
      currentSenseTrip, currentSenseQuarterTrip, auxDemagDone, auxValley, auxOpen,
      auxOvpEvent, loopControlAbove2v5, loopControlAbove4v5, loopControlShorted,
      loopControlFreqRedEnter, loopControlFreqRedExit}),
    .syncOut(syncIn)
  );

  assign {supUp, supLow, busStart, ssDone, csTrip, csQuarter, demag, valley, auxOpn,
    ovpEv, lc25, lc45, lcShort, frEnter, frExit} = syncIn;

  // ****************************************************************
  // Control state.
  // ****************************************************************
  fsc_pkg::fsc_state_t state_q;
  logic freqRed_q;
  logic [PERIOD_WIDTH-1:0] osc_q;
  logic oscHigh;
  logic [15:0] onCnt_q;
  logic [15:0] blankCnt_q;
  logic [3:0] ovpCnt_q;
  logic ovpSeen_q;
  logic inhibit;
  logic endOn;
  logic maxOnHit;
  logic [PERIOD_WIDTH-1:0] periodLimit;

  localparam logic [PERIOD_WIDTH-1:0] MIN_PERIOD = PERIOD_WIDTH'(fsc_pkg::MIN_PERIOD_CYC);
  localparam logic [15:0] ON_LIMIT = 16'(MAX_ON_CYCLES);
  localparam logic [15:0] LEB = 16'(fsc_pkg::LEB_CYC);
  localparam logic [15:0] DEMAG_BLANK = 16'(fsc_pkg::DEMAG_BLANK_CYC);
  localparam logic [3:0] OVP_TRIP = 4'(fsc_pkg::OVP_TRIP);
  localparam logic [3:0] OVP_UP = 4'(fsc_pkg::OVP_UP);
  localparam logic [3:0] OVP_DOWN = 4'(fsc_pkg::OVP_DOWN);

  // Faults that stop switching; all but the overvoltage latch clear without a restart.
  assign inhibit = auxOpn || lc45 || lcShort || ovpLatched;

  // Never faster than the maximum frequency; in frequency reduction the oscillator may ask for longer.
  assign periodLimit = (freqRed_q && (oscPeriodCycles > MIN_PERIOD)) ? oscPeriodCycles : MIN_PERIOD;
  assign oscHigh = (osc_q >= periodLimit);

  // Leading-edge blanking masks the current comparators right after turn-on.
  assign endOn = (onCnt_q >= LEB) && (freqRed_q ? csQuarter : csTrip);
  assign maxOnHit = (onCnt_q >= ON_LIMIT - 16'h0001);

  // ****************************************************************
  // Frequency reduction mode with hysteresis.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      freqRed_q <= 1'b0;
    end else if (!freqRed_q && frEnter) begin
      freqRed_q <= 1'b1;
    end else if (freqRed_q && frExit) begin
      freqRed_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Main sequencer.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= fsc_pkg::ST_WAIT_SUPPLY;
    end else if (supLow || safeRestart) begin
      state_q <= fsc_pkg::ST_WAIT_SUPPLY;
    end else begin
      unique case (state_q)
        fsc_pkg::ST_WAIT_SUPPLY: begin
          if (supUp) begin
            state_q <= fsc_pkg::ST_SOFT_START;
          end
        end
        fsc_pkg::ST_SOFT_START: begin
          if (busStart && ssDone && !inhibit) begin
            state_q <= fsc_pkg::ST_ON;
          end
        end
        fsc_pkg::ST_ON: begin
          if (inhibit || endOn || maxOnHit) begin
            state_q <= fsc_pkg::ST_SECONDARY;
          end
        end
        fsc_pkg::ST_SECONDARY: begin
          // A slow demag simply keeps us here, stretching the off-time.
          if ((blankCnt_q >= DEMAG_BLANK) && demag) begin
            state_q <= fsc_pkg::ST_WAIT_VALLEY;
          end
        end
        fsc_pkg::ST_WAIT_VALLEY: begin
          if (oscHigh && valley && !inhibit) begin
            state_q <= fsc_pkg::ST_ON;
          end
        end
        fsc_pkg::ST_HALT: begin
          state_q <= fsc_pkg::ST_WAIT_SUPPLY;
        end
      endcase
    end
  end

  // ****************************************************************
  // Gate latch: set on the valley launch or the soft-start launch, cleared at end of on-time.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      gateDriveOutput <= 1'b0;
    end else if (supLow || safeRestart || inhibit) begin
      gateDriveOutput <= 1'b0;
    end else if (state_q == fsc_pkg::ST_ON) begin
      if (endOn || maxOnHit) begin
        gateDriveOutput <= 1'b0;
      end
    end else if (((state_q == fsc_pkg::ST_WAIT_VALLEY) && oscHigh && valley) ||
                 ((state_q == fsc_pkg::ST_SOFT_START) && busStart && ssDone)) begin
      gateDriveOutput <= 1'b1;
    end
  end

  // ****************************************************************
  // Timers: oscillator, on-time, demag blanking.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst || (state_q == fsc_pkg::ST_ON) && (onCnt_q == 16'h0000)) begin
      osc_q <= '0;
    end else if (!oscHigh) begin
      osc_q <= osc_q + PERIOD_WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst || (state_q != fsc_pkg::ST_ON)) begin
      onCnt_q <= 16'h0000;
    end else begin
      onCnt_q <= onCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || (state_q != fsc_pkg::ST_SECONDARY)) begin
      blankCnt_q <= 16'h0000;
    end else if (blankCnt_q < DEMAG_BLANK) begin
      blankCnt_q <= blankCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      safeRestart <= 1'b0;
    end else begin
      safeRestart <= (state_q == fsc_pkg::ST_ON) && maxOnHit && !endOn;
    end
  end

  // ****************************************************************
  // Overvoltage counter and latch.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst || (state_q == fsc_pkg::ST_ON)) begin
      ovpSeen_q <= 1'b0;
    end else if ((state_q == fsc_pkg::ST_SECONDARY) && ovpEv) begin
      ovpSeen_q <= 1'b1;
    end
  end

  // Counter settles once per cycle, at the valley turn-on.
  // Valleys seen while a fault holds the gate off are not turn-ons, so they leave the count alone.
  // A full count would set the latch again at once, so the supply collapse empties it as well.
  always_ff @(posedge clk) begin
    if (srst || supLow) begin
      ovpCnt_q <= 4'h0;
    end else if ((state_q == fsc_pkg::ST_WAIT_VALLEY) && oscHigh && valley && !inhibit) begin
      if (ovpSeen_q) begin
        ovpCnt_q <= (ovpCnt_q < OVP_TRIP) ? ovpCnt_q + OVP_UP : ovpCnt_q;
      end else begin
        ovpCnt_q <= (ovpCnt_q > OVP_DOWN) ? ovpCnt_q - OVP_DOWN : 4'h0;
      end
    end
  end

  // The supply collapse is the only way out of the latch.
  always_ff @(posedge clk) begin
    if (srst) begin
      ovpLatched <= 1'b0;
    end else if (ovpCnt_q >= OVP_TRIP) begin
      ovpLatched <= 1'b1;
    end else if (supLow) begin
      ovpLatched <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin bias and mode outputs.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      softStartCurrentEn <= 1'b0;
      loopPullupEn <= 1'b1;
      burstModeReq <= 1'b0;
      peakLimitQuarter <= 1'b0;
    end else begin
      softStartCurrentEn <= (state_q == fsc_pkg::ST_SOFT_START);
      loopPullupEn <= !lc25;
      burstModeReq <= freqRed_q;
      peakLimitQuarter <= freqRed_q;
    end
  end

endmodule : fsc_flyback_switching_controller
`default_nettype wire

// [tb/fsc_stage.sv]
// Behavioural power stage and auxiliary winding facing the controller.
`timescale 1ns/1ps
`default_nettype none
module fsc_stage (
  // Clock and gate.
  input wire logic clk,
  input wire logic gate,
  // Stroke timing in clock cycles.
  input wire logic [15:0] tripCyc,
  input wire logic [15:0] demagCyc,
  // Comparator results.
  output logic trip,
  output logic qTrip,
  output logic demag,
  output logic valley
);
  logic gate_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  // The count restarts on every gate edge, so on-time and off-time are timed apart.
  always @(posedge clk) begin
    gate_q <= gate;
    cnt_q <= (gate !== gate_q) ? 16'h0000 : cnt_q + 16'h0001;
    trip <= gate && cnt_q > tripCyc;
    qTrip <= gate && cnt_q > 16'h005A;
    demag <= !gate && cnt_q >= demagCyc;
    valley <= demag && cnt_q[3:0] == 4'hF;
  end
endmodule : fsc_stage
`default_nettype wire

// [tb/fsc_props.sv]
// Port assertions for the flyback switching controller.
`timescale 1ns/1ps
`default_nettype none
module fsc_props #(
  parameter int unsigned MAX_ON_CYCLES = 6250
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Inputs.
  input wire logic supplyUvlo,
  input wire logic auxOpen,
  input wire logic loopControlAbove2v5,
  input wire logic loopControlAbove4v5,
  input wire logic loopControlShorted,
  // Outputs.
  input wire logic gateDriveOutput,
  input wire logic softStartCurrentEn,
  input wire logic loopPullupEn,
  input wire logic burstModeReq,
  input wire logic peakLimitQuarter,
  input wire logic ovpLatched,
  input wire logic safeRestart
);
  logic gate_q;
  logic [15:0] onCnt_q;
  logic [15:0] gapCnt_q;
  always_ff @(posedge clk) begin
    gate_q <= gateDriveOutput;
    onCnt_q <= (srst || !gateDriveOutput) ? 16'h0000 : onCnt_q + 16'h0001;
  end
  // The gap saturates after a restart so a fresh start-up is never flagged.
  always_ff @(posedge clk) begin
    if (srst || safeRestart || supplyUvlo) gapCnt_q <= 16'hFFFF;
    else if (gateDriveOutput && !gate_q) gapCnt_q <= 16'h0001;
    else if (gapCnt_q != 16'hFFFF) gapCnt_q <= gapCnt_q + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_held(sig);
    sig [*5];
  endsequence
  property p_open; s_held(auxOpen) |-> !gateDriveOutput; endproperty
  a_open: assert property (p_open) else $error("gate on, aux open");
  property p_loopHigh; s_held(loopControlAbove4v5) |-> !gateDriveOutput; endproperty
  a_loopHigh: assert property (p_loopHigh) else $error("gate on, loop high");
  property p_loopShort; s_held(loopControlShorted) |-> !gateDriveOutput; endproperty
  a_loopShort: assert property (p_loopShort) else $error("gate on, loop short");
  property p_pullup; s_held($stable(loopControlAbove2v5)) |-> loopPullupEn != loopControlAbove2v5; endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");
  property p_mode; burstModeReq == peakLimitQuarter; endproperty
  a_mode: assert property (p_mode) else $error("burst and quarter differ");
  property p_softOff; $rose(gateDriveOutput) |-> ##[1:2] !softStartCurrentEn; endproperty
  a_softOff: assert property (p_softOff) else $error("soft start left on");
  property p_safe; safeRestart |=> !safeRestart && !gateDriveOutput; endproperty
  a_safe: assert property (p_safe) else $error("safe restart wrong");
  property p_ovpOff; ovpLatched [*2] |-> !gateDriveOutput; endproperty
  a_ovpOff: assert property (p_ovpOff) else $error("gate on, latched");
  property p_ovpHold; $fell(ovpLatched) |-> $past(supplyUvlo, 2) || $past(supplyUvlo, 3) || $past(supplyUvlo, 4); endproperty
  a_ovpHold: assert property (p_ovpHold) else $error("latch cleared early");
  property p_maxOn; onCnt_q <= MAX_ON_CYCLES + 4; endproperty
  a_maxOn: assert property (p_maxOn) else $error("on-time too long");
  property p_gap; $rose(gateDriveOutput) |-> gapCnt_q >= fsc_pkg::MIN_PERIOD_CYC; endproperty
  a_gap: assert property (p_gap) else $error("period too short");
endmodule : fsc_props
bind fsc_flyback_switching_controller fsc_props #(.MAX_ON_CYCLES(MAX_ON_CYCLES)) u_props (
  .clk, .srst, .supplyUvlo, .auxOpen, .loopControlAbove2v5, .loopControlAbove4v5, .loopControlShorted,
  .gateDriveOutput, .softStartCurrentEn, .loopPullupEn, .burstModeReq, .peakLimitQuarter, .ovpLatched, .safeRestart
);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the flyback switching controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int MAXON = 200;
  logic clk = 1'b0, srst = 1'b1, supplyStartup = 1'b0, supplyUvlo = 1'b0;
  logic busOutputSenseStart = 1'b0, currentSenseSoftDone = 1'b0, auxOpen = 1'b0, auxOvpEvent = 1'b0;
  logic loopControlAbove2v5 = 1'b0, loopControlAbove4v5 = 1'b0, loopControlShorted = 1'b0;
  logic loopControlFreqRedEnter = 1'b0, loopControlFreqRedExit = 1'b0, safeSeen = 1'b0;
  logic [15:0] oscPeriodCycles = 16'h0FA0, tripCyc = 16'h0008, demagCyc = 16'h0028;
  wire currentSenseTrip, currentSenseQuarterTrip, auxDemagDone, auxValley, gateDriveOutput;
  wire softStartCurrentEn, loopPullupEn, burstModeReq, peakLimitQuarter, ovpLatched, safeRestart;
  int n_mismatch = 0, check_count = 0, cycles = 0, w, p;
  fsc_flyback_switching_controller #(.MAX_ON_CYCLES(MAXON)) uut (
    .clk, .srst, .supplyStartup, .supplyUvlo, .busOutputSenseStart, .currentSenseSoftDone, .currentSenseTrip,
    .currentSenseQuarterTrip, .auxDemagDone, .auxValley, .auxOpen, .auxOvpEvent, .loopControlAbove2v5,
    .loopControlAbove4v5, .loopControlShorted, .loopControlFreqRedEnter, .loopControlFreqRedExit,
    .oscPeriodCycles, .gateDriveOutput, .softStartCurrentEn, .loopPullupEn, .burstModeReq, .peakLimitQuarter,
    .ovpLatched, .safeRestart
  );
  fsc_stage stage (.clk, .gate(gateDriveOutput), .tripCyc, .demagCyc, .trip(currentSenseTrip),
    .qTrip(currentSenseQuarterTrip), .demag(auxDemagDone), .valley(auxValley));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (safeRestart === 1'b1) safeSeen = 1'b1;
    if (cycles == 95000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string nm, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, exp, seen);
    end
  endtask : check
  task automatic wait_gate(input logic v, input int lim);
    w = 0;
    while (gateDriveOutput !== v && w < lim) begin
      tick(1);
      w++;
    end
  endtask : wait_gate
  // Measures one full switching period, from just after one turn-on to the next.
  task automatic next_rise();
    wait_gate(1'b0, 400);
    p = w;
    wait_gate(1'b1, 4500);
    p += w;
  endtask : next_rise
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_start();
    supplyStartup = 1'b1;
    busOutputSenseStart = 1'b1;
    tick(20);
    check("softStart", softStartCurrentEn, 1'b1);
    check("noStart", gateDriveOutput, 1'b0);
    currentSenseSoftDone = 1'b1;
    wait_gate(1'b1, 8);
    check("start", gateDriveOutput, 1'b1);
    wait_gate(1'b0, 400);
    check("onTime", w >= 70 && w < 100, 1'b1);
    p = w;
    wait_gate(1'b1, 4500);
    p += w;
    check("capPeriod", p >= 1998 && p < 2040, 1'b1);
  endtask : t_start
  task automatic t_fault();
    loopControlAbove2v5 = 1'b1;
    tick(6);
    check("pullupOff", loopPullupEn, 1'b0);
    loopControlAbove2v5 = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {auxOpen, loopControlAbove4v5, loopControlShorted} = 3'b100 >> i;
      tick(6);
      wait_gate(1'b1, 3000);
      check("faultHold", gateDriveOutput, 1'b0);
      {auxOpen, loopControlAbove4v5, loopControlShorted} = 3'b000;
      wait_gate(1'b1, 3000);
      check("resume", gateDriveOutput, 1'b1);
    end
  endtask : t_fault
  task automatic t_freq();
    loopControlFreqRedEnter = 1'b1;
    tick(6);
    check("quarter", peakLimitQuarter, 1'b1);
    loopControlFreqRedEnter = 1'b0;
    tripCyc = 16'h008C;
    next_rise();
    next_rise();
    check("burstHeld", burstModeReq, 1'b1);
    check("vcoPeriod", p >= 3998 && p < 4100, 1'b1);
    wait_gate(1'b0, 400);
    check("quarterOn", w > 80 && w < 120, 1'b1);
    loopControlFreqRedExit = 1'b1;
    tick(6);
    check("burstOff", burstModeReq, 1'b0);
    loopControlFreqRedExit = 1'b0;
    tripCyc = 16'h0008;
  endtask : t_freq
  task automatic t_slow();
    demagCyc = 16'h0BB8;
    next_rise();
    next_rise();
    check("slowDemag", p >= 3000 && p < 3150, 1'b1);
    demagCyc = 16'h0028;
  endtask : t_slow
  task automatic t_maxon();
    tripCyc = 16'hFFFF;
    next_rise();
    supplyStartup = 1'b0;
    currentSenseSoftDone = 1'b0;
    wait_gate(1'b0, 400);
    check("maxOn", w >= MAXON - 4 && w <= MAXON + 4, 1'b1);
    check("safePulse", safeSeen, 1'b1);
    tripCyc = 16'h0008;
    wait_gate(1'b1, 1000);
    check("idle", gateDriveOutput, 1'b0);
    supplyStartup = 1'b1;
    tick(6);
    check("reSoft", softStartCurrentEn, 1'b1);
    currentSenseSoftDone = 1'b1;
    wait_gate(1'b1, 8);
    check("reStart", gateDriveOutput, 1'b1);
  endtask : t_maxon
  task automatic t_ovp();
    auxOvpEvent = 1'b1;
    repeat (5) next_rise();
    auxOvpEvent = 1'b0;
    repeat (3) next_rise();
    auxOvpEvent = 1'b1;
    repeat (6) next_rise();
    check("ovpDown", ovpLatched, 1'b0);
    repeat (2) next_rise();
    for (w = 0; ovpLatched !== 1'b1 && w < 2500; w++) tick(1);
    check("ovpTrip", ovpLatched, 1'b1);
    tick(3000);
    check("ovpHold", ovpLatched, 1'b1);
    supplyUvlo = 1'b1;
    tick(8);
    supplyUvlo = 1'b0;
    check("ovpClear", ovpLatched, 1'b0);
  endtask : t_ovp
  initial begin
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    tick(4);
    t_start();
    t_fault();
    t_freq();
    t_slow();
    t_maxon();
    t_ovp();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
